// >>> pll_serial_control_host.sv
// Purpose: host end, shifts command words onto the three-wire link
// Assumes: serial clock made here by dividing clock_i
// Notes: channel words are refused until reference and control are loaded
`include "pll_serial_control_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pll_serial_control_host (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic supply_ok_i,
	input wire logic cmd_valid_i,
	input wire pll_serial_control_pkg::group_t cmd_group_i,
	input wire logic [16:0] cmd_payload_i,
	output logic cmd_ready_o,
	output logic cmd_refused_o,
	output logic cmd_done_o,
	pll_serial_link_if.host_end link
);
	import pll_serial_control_pkg::*;

	typedef struct packed {
		host_state_t st;
		logic [3:0] cnt;
		logic [4:0] idx;
		logic [4:0] last;
		logic [`SR_W-1:0] word;
		group_t grp;
		logic sck;
		logic sdat;
		logic sen;
		logic ref_loaded;
		logic ctl_loaded;
		logic refused;
		logic done;
	} host_st_t;

	host_st_t q, d;
	logic tick;
	logic is_chan;

	// ==========================================
	// next state
	always_comb begin
		d = q;
		d.refused = 1'b0;
		d.done = 1'b0;
		tick = (q.cnt == 4'h0);
		is_chan = (cmd_group_i == GRP_CHAN_ONE) | (cmd_group_i == GRP_CHAN_TWO);
		if (!tick) begin
			d.cnt = 4'(q.cnt - 4'h1);
		end
		unique case (q.st)
			H_IDLE: begin
				if (cmd_valid_i && supply_ok_i) begin
					if (is_chan && !(q.ref_loaded && q.ctl_loaded)) begin
						d.refused = 1'b1; // [RULE15] [RULE16]
					end else begin
						d.grp = cmd_group_i;
						if (is_chan) begin
							d.word = {cmd_group_i[1], cmd_group_i[0], cmd_payload_i};
							d.last = 5'(`LONG_WORD_BITS - 1);
						end else begin
							d.word = {5'h0, cmd_group_i[1], cmd_group_i[0], cmd_payload_i[11:0]};
							d.last = 5'(`SHORT_WORD_BITS - 1);
						end
						d.idx = 5'h0;
						d.sdat = d.word[0]; // [RULE1]
						d.sck = 1'b0;
						d.cnt = `HALF_LOAD;
						d.st = H_SET;
					end
				end
			end
			H_SET: begin
				if (tick) begin
					d.sck = 1'b1;
					d.cnt = `HALF_LOAD;
					d.st = H_RISE;
				end
			end
			H_RISE: begin
				if (tick) begin
					d.sck = 1'b0;
					d.cnt = `HALF_LOAD;
					if (q.idx == q.last) begin
						d.sen = 1'b1; // [RULE3]
						d.sdat = 1'b0;
						d.cnt = `LATCH_LOAD;
						d.st = H_LATCH;
					end else begin
						d.word = {1'b0, q.word[`SR_W-1:1]}; // [RULE1]
						d.sdat = q.word[1];
						d.idx = 5'(q.idx + 5'h1);
						d.st = H_SET;
					end
				end
			end
			H_LATCH: begin
				if (tick) begin
					d.sen = 1'b0;
					d.cnt = `HALF_LOAD;
					d.st = H_GAP;
				end
			end
			H_GAP: begin
				if (tick) begin
					d.done = 1'b1;
					d.ref_loaded = q.ref_loaded | (q.grp == GRP_REFERENCE);
					d.ctl_loaded = q.ctl_loaded | (q.grp == GRP_CONTROL);
					d.st = H_IDLE;
				end
			end
			default: d.st = H_IDLE;
		endcase
		if (!supply_ok_i) begin
			d.st = H_IDLE; // [RULE17]
			d.sck = 1'b0;
			d.sdat = 1'b0;
			d.sen = 1'b0;
			d.cnt = 4'h0;
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign cmd_ready_o = (q.st == H_IDLE) & supply_ok_i;
	assign cmd_refused_o = q.refused;
	assign cmd_done_o = q.done;
	assign link.sck = q.sck;
	assign link.sdata = q.sdat;
	assign link.sen = q.sen;
endmodule
`default_nettype wire

// >>> pll_serial_control_latch.sv
// Purpose: device end, serial shift register, latches, lock detector and lock pin mux
// Assumes: divider and tap inputs are logic on clock_i; clock_i stands in for the crystal
// Notes: link pins pass three flops; a change counts once stages two and three agree
// Operation
// RULE1: words arrive least significant bit first
// RULE2: each rising serial clock shifts one bit
// RULE3: enable high latches the complete shifted word
// RULE4: final two bits pick the target latch
// RULE5: control word holds fourteen fixed-order bits
// RULE6: diag_mode one selects test mode
// RULE7: pump_polarity one reverses charge pump
// RULE8: current pair selects 1600/200/400/800 uA
// RULE9: both awake: selector picks lock pin source
// RULE10: sleeping channel reads as locked in selection
// RULE11: test mode puts internal taps on pin; code does so only while exactly one channel sleeps, pin low otherwise
// RULE12: lock pin low on error, high locked
// RULE13: lock after four aligned reference cycles
// RULE14: reference sleeps only when both channels sleep
// RULE15: host loads reference before channel latches
// RULE16: host loads control before channel latches
// RULE17: host holds pins low without supply
// RULE18: reference latch keeps twelve-bit divide value
// RULE19: channel latch keeps swallow and main counts
// RULE20: filter bit drives open-drain filter switch
// RULE21: only the addressed latch is updated
`include "pll_serial_control_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pll_serial_control_latch (
	input wire logic clock_i,
	input wire logic rst_i,
	pll_serial_link_if.device_end link,
	input wire logic ref_pulse_i,
	input wire logic [1:0] chan_pulse_i,
	input wire logic ref_freq_i,
	input wire logic chan_one_modulus_tap_i,
	input wire logic chan_two_modulus_tap_i,
	input wire logic chan_one_divided_freq_i,
	input wire logic chan_two_divided_freq_i,
	input wire logic quarter_rate_tap_i,
	input wire logic half_osc_i,
	output var pll_serial_control_pkg::control_word_t control_word_o,
	output logic test_mode_o,
	output logic pump_reversed_o,
	output logic [10:0] chan_one_pump_ua_o,
	output logic [10:0] chan_two_pump_ua_o,
	output logic chan_one_power_o,
	output logic chan_two_power_o,
	output logic ref_power_o,
	output logic [11:0] ref_divide_o,
	output logic [12:0] ref_ratio_o,
	output logic [4:0] chan_one_swallow_o,
	output logic [11:0] chan_one_main_o,
	output logic [4:0] chan_two_swallow_o,
	output logic [11:0] chan_two_main_o,
	output logic [1:0] chan_locked_o
);
	import pll_serial_control_pkg::*;

	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] sdat_s;
		logic [2:0] sen_s;
		logic sck_f;
		logic sen_f;
		logic [`SR_W-1:0] shift;
		control_word_t ctrl;
		logic [`REF_W-1:0] ref_div;
		logic [1:0][`SWAL_W-1:0] swallow;
		logic [1:0][`MAIN_W-1:0] main;
		logic ref_d;
		logic [1:0] ch_d1;
		logic [1:0] ch_d2;
		logic [1:0][2:0] streak;
		logic lock_pin;
	} dev_state_t;

	dev_state_t q, d;
	logic sck_rise;
	logic sen_rise;
	logic [1:0] sleep;
	logic [1:0] lk;
	logic [1:0] sel;
	logic win_hit;

	function automatic logic [10:0] pump_ua(input logic [1:0] code);
		case (code)
			2'h0: pump_ua = `PUMP_UA_00;
			2'h1: pump_ua = `PUMP_UA_01;
			2'h2: pump_ua = `PUMP_UA_10;
			default: pump_ua = `PUMP_UA_11;
		endcase
	endfunction

	// ==========================================
	// next state
	always_comb begin
		d = q;
		sck_rise = 1'b0;
		sen_rise = 1'b0;
		win_hit = 1'b0;
		d.sck_s = {q.sck_s[1:0], link.sck};
		d.sdat_s = {q.sdat_s[1:0], link.sdata};
		d.sen_s = {q.sen_s[1:0], link.sen};
		if (q.sck_s[1] == q.sck_s[2]) begin
			d.sck_f = q.sck_s[2];
		end
		if (q.sen_s[1] == q.sen_s[2]) begin
			d.sen_f = q.sen_s[2];
		end
		sck_rise = d.sck_f & ~q.sck_f;
		sen_rise = d.sen_f & ~q.sen_f;
		if (sck_rise) begin
			d.shift = {q.sdat_s[2], q.shift[`SR_W-1:1]}; // [RULE1] [RULE2]
		end
		if (sen_rise) begin
			unique case (group_t'({q.shift[`GC_HI_BIT], q.shift[`GC_LO_BIT]})) // [RULE3] [RULE4] [RULE21]
				GRP_CONTROL: begin
					d.ctrl.diag_mode = q.shift[`CTL_DIAG]; // [RULE5]
					d.ctrl.pump_polarity = q.shift[`CTL_POL];
					d.ctrl.chan_one_current = {q.shift[`CTL_CUR1_A], q.shift[`CTL_CUR1_B]};
					d.ctrl.chan_one_sleep = q.shift[`CTL_SLEEP1];
					d.ctrl.chan_two_current = {q.shift[`CTL_CUR2_A], q.shift[`CTL_CUR2_B]};
					d.ctrl.chan_two_sleep = q.shift[`CTL_SLEEP2];
					d.ctrl.ref_divider_sleep = q.shift[`CTL_SLEEPR];
					d.ctrl.lock_out_sel_a = q.shift[`CTL_SEL_A];
					d.ctrl.lock_out_sel_b = q.shift[`CTL_SEL_B];
					d.ctrl.filter_time_constant_sel = q.shift[`CTL_FILT];
				end
				GRP_CHAN_ONE: begin
					d.swallow[0] = q.shift[`SWAL_LSB +: `SWAL_W]; // [RULE19]
					d.main[0] = q.shift[`MAIN_LSB +: `MAIN_W];
				end
				GRP_CHAN_TWO: begin
					d.swallow[1] = q.shift[`SWAL_LSB +: `SWAL_W]; // [RULE19]
					d.main[1] = q.shift[`MAIN_LSB +: `MAIN_W];
				end
				GRP_REFERENCE: begin
					d.ref_div = q.shift[`REF_LSB +: `REF_W]; // [RULE18]
				end
			endcase
		end
		// lock detector: channel edge within one clock either side of the reference
		sleep = {q.ctrl.chan_two_sleep, q.ctrl.chan_one_sleep};
		d.ref_d = ref_pulse_i;
		d.ch_d1 = chan_pulse_i;
		d.ch_d2 = q.ch_d1;
		for (int c = 0; c < 2; c++) begin
			win_hit = q.ch_d2[c] | q.ch_d1[c] | chan_pulse_i[c];
			if (sleep[c]) begin
				d.streak[c] = 3'h0;
			end else if (q.ref_d) begin
				if (!win_hit) begin
					d.streak[c] = 3'h0; // [RULE13]
				end else if (q.streak[c] != `LOCK_STREAK) begin
					d.streak[c] = 3'(q.streak[c] + 3'h1); // [RULE13]
				end
			end
			lk[c] = (q.streak[c] == `LOCK_STREAK) | sleep[c]; // [RULE12]
		end
		sel = {q.ctrl.lock_out_sel_a, q.ctrl.lock_out_sel_b};
		d.lock_pin = 1'b0;
		if (!q.ctrl.diag_mode) begin
			unique case (sel) // [RULE6] [RULE9] [RULE10]
				2'h0: d.lock_pin = 1'b0;
				2'h1: d.lock_pin = lk[1];
				2'h2: d.lock_pin = lk[0];
				2'h3: d.lock_pin = lk[0] & lk[1];
			endcase
		end else if (sleep == 2'h1) begin
			unique case (sel) // [RULE11]
				2'h0: d.lock_pin = 1'b0;
				2'h1: d.lock_pin = chan_two_modulus_tap_i;
				2'h2: d.lock_pin = chan_two_divided_freq_i;
				2'h3: d.lock_pin = ref_freq_i;
			endcase
		end else if (sleep == 2'h2) begin
			unique case (sel) // [RULE11]
				2'h0: d.lock_pin = quarter_rate_tap_i;
				2'h1: d.lock_pin = chan_one_modulus_tap_i;
				2'h2: d.lock_pin = chan_one_divided_freq_i;
				2'h3: d.lock_pin = half_osc_i;
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// outputs
	assign control_word_o = q.ctrl;
	assign test_mode_o = q.ctrl.diag_mode; // [RULE6]
	assign pump_reversed_o = q.ctrl.pump_polarity; // [RULE7]
	assign chan_one_pump_ua_o = pump_ua(q.ctrl.chan_one_current); // [RULE8]
	assign chan_two_pump_ua_o = pump_ua(q.ctrl.chan_two_current); // [RULE8]
	assign chan_one_power_o = ~q.ctrl.chan_one_sleep; // [RULE14]
	assign chan_two_power_o = ~q.ctrl.chan_two_sleep;
	assign ref_power_o = ~(q.ctrl.chan_one_sleep & q.ctrl.chan_two_sleep
		& q.ctrl.ref_divider_sleep); // [RULE14]
	assign ref_divide_o = q.ref_div;
	assign ref_ratio_o = {q.ref_div, 1'b0}; // [RULE18]
	assign chan_one_swallow_o = q.swallow[0];
	assign chan_one_main_o = q.main[0];
	assign chan_two_swallow_o = q.swallow[1];
	assign chan_two_main_o = q.main[1];
	assign chan_locked_o = {q.streak[1] == `LOCK_STREAK, q.streak[0] == `LOCK_STREAK};
	assign link.lock_flag_oe = ~q.lock_pin; // [RULE12]
	assign link.filter_switch_oe = q.ctrl.filter_time_constant_sel; // [RULE20]
endmodule
`default_nettype wire

// >>> pll_serial_control_latch_checker.sv
// Purpose: watches the three-wire link between host end and device end
// Assumes: one clock domain, link pins sampled on clock_i
// Notes: both parties are design code
`timescale 1ns/10ps
`default_nettype none
module pll_serial_control_latch_checker (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sck,
	input wire logic sdata,
	input wire logic sen,
	input wire logic filter_switch_oe
);
	// ====================
	// helper: serial clock rises since last enable
	logic sck_q;
	logic [4:0] rises_q;
	always_ff @(posedge clock_i) begin
		sck_q <= sck;
		if (rst_i || sen) begin
			rises_q <= 5'h00;
		end else if (sck && !sck_q) begin
			rises_q <= rises_q + 5'h01;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ====================
	// properties
	sck_high_a: assert property ($rose(sck) |-> sck [*4])
		else $error("serial clock high phase too short");
	sck_low_a: assert property ($fell(sck) |-> !sck [*4])
		else $error("serial clock low phase too short");
	data_stable_a: assert property ((sck && $past(sck)) |-> $stable(sdata))
		else $error("data moved while clock high");
	sen_idle_a: assert property (sen |-> !sck && (!$past(sen) || $stable(sck)))
		else $error("clock moved while enable high");
	sen_width_a: assert property ($rose(sen) |-> sen [*8] ##1 !sen [*4])
		else $error("enable pulse or gap wrong");
	sen_gap_a: assert property ($fell(sen) |-> !sck [*4])
		else $error("clock rose right after enable");
	word_bits_a: assert property ($rose(sen) |-> rises_q == 5'h0e || rises_q == 5'h13)
		else $error("word length not 14 or 19");
	filter_latch_a: assert property ($changed(filter_switch_oe) |-> sen)
		else $error("filter switch moved outside a latch");
endmodule
`default_nettype wire

// >>> pll_serial_control_latch_test.sv
// Purpose: self-checking bench of host end and device end
// Assumes: clock_i 25 MHz, serial clock made by the host end
// Notes: lock pin reads high when released
`timescale 1ns/10ps
`default_nettype none
module pll_serial_control_latch_test;
	import pll_serial_control_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic supply_ok, cmd_valid, cmd_ready, cmd_refused, cmd_done, ref_pulse;
	logic test_mode, pump_rev, pow1, pow2, powr;
	group_t cmd_group;
	logic [16:0] cmd_payload;
	logic [1:0] chan_pulse, chan_locked;
	logic [6:0] taps;
	control_word_t cw;
	logic [10:0] ua1, ua2;
	logic [11:0] ref_div, main1, main2;
	logic [12:0] ref_ratio;
	logic [4:0] swal1, swal2;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	// ====================
	// ends and checker
	pll_serial_link_if link ();
	pll_serial_control_host pll_serial_control_host_inst (.clock_i(clock_i), .rst_i(rst_i),
		.supply_ok_i(supply_ok), .cmd_valid_i(cmd_valid), .cmd_group_i(cmd_group),
		.cmd_payload_i(cmd_payload), .cmd_ready_o(cmd_ready), .cmd_refused_o(cmd_refused),
		.cmd_done_o(cmd_done), .link(link));
	pll_serial_control_latch pll_serial_control_latch_inst (.clock_i(clock_i), .rst_i(rst_i),
		.link(link), .ref_pulse_i(ref_pulse), .chan_pulse_i(chan_pulse), .ref_freq_i(taps[6]),
		.chan_one_modulus_tap_i(taps[1]), .chan_two_modulus_tap_i(taps[4]),
		.chan_one_divided_freq_i(taps[2]), .chan_two_divided_freq_i(taps[5]),
		.quarter_rate_tap_i(taps[0]), .half_osc_i(taps[3]), .control_word_o(cw),
		.test_mode_o(test_mode), .pump_reversed_o(pump_rev), .chan_one_pump_ua_o(ua1),
		.chan_two_pump_ua_o(ua2), .chan_one_power_o(pow1), .chan_two_power_o(pow2),
		.ref_power_o(powr), .ref_divide_o(ref_div), .ref_ratio_o(ref_ratio),
		.chan_one_swallow_o(swal1), .chan_one_main_o(main1), .chan_two_swallow_o(swal2),
		.chan_two_main_o(main2), .chan_locked_o(chan_locked));
	pll_serial_control_latch_checker pll_serial_control_latch_checker_inst (.clock_i(clock_i),
		.rst_i(rst_i), .sck(link.sck), .sdata(link.sdata), .sen(link.sen),
		.filter_switch_oe(link.filter_switch_oe));
	// ====================
	// shared tasks
	task automatic report_and_stop();
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [16:0] ctl(input logic diag, pol, input logic [1:0] c1,
		input logic s1, input logic [1:0] c2, input logic s2, sr, input logic [1:0] sel,
		input logic filt);
		return {5'h00, filt, sel[0], sel[1], sr, s2, c2[0], c2[1], s1, c1[0], c1[1], pol, diag};
	endfunction
	function automatic logic [10:0] ua(input logic [1:0] c);
		return (c == 2'h0) ? 11'h640 : (11'h0c8 << (c - 2'h1));
	endfunction
	task automatic send(input group_t g, input logic [16:0] p, output logic refused);
		int n;
		@(negedge clock_i);
		while (cmd_ready !== 1'b1) @(negedge clock_i);
		cmd_group = g;
		cmd_payload = p;
		cmd_valid = 1'b1;
		@(negedge clock_i);
		cmd_valid = 1'b0;
		for (n = 0; n < 400 && cmd_done !== 1'b1 && cmd_refused !== 1'b1; n++) @(negedge clock_i);
		refused = cmd_refused;
		check("command end", n < 400, 1);
	endtask
	task automatic pulse(input int n, input logic [1:0] m);
		repeat (n) begin
			@(negedge clock_i);
			ref_pulse = 1'b1;
			chan_pulse = m;
			@(negedge clock_i);
			ref_pulse = 1'b0;
			chan_pulse = 2'h0;
			repeat (14) @(negedge clock_i);
		end
	endtask
	// ====================
	// scenarios
	task automatic t_order();
		logic r;
		send(GRP_CHAN_ONE, 17'h00000, r);
		check("early channel", r, 1);
		send(GRP_CONTROL, ctl(0, 0, 2'h0, 0, 2'h0, 0, 0, 2'h3, 0), r);
		check("control accepted", r, 0);
		send(GRP_CHAN_TWO, 17'h00000, r);
		check("channel before reference", r, 1);
		send(GRP_REFERENCE, 17'h00352, r);
		check("ref divide", ref_div, 12'h352);
		check("ref ratio", ref_ratio, 13'h06a4);
		send(GRP_CHAN_ONE, {12'h236, 5'h08}, r);
		check("ch1 main", main1, 12'h236);
		check("ch1 swallow", swal1, 5'h08);
		send(GRP_CHAN_TWO, {12'h242, 5'h14}, r);
		check("ch2 main", main2, 12'h242);
		check("ch2 swallow", swal2, 5'h14);
		check("ch1 kept", main1, 12'h236);
		check("ref kept", ref_div, 12'h352);
		check("control kept", cw.lock_out_sel_a, 1);
		supply_ok = 1'b0;
		repeat (3) @(negedge clock_i);
		check("link low", {cmd_ready, link.sck, link.sdata, link.sen}, 0);
		supply_ok = 1'b1;
	endtask
	task automatic t_normal();
		logic r;
		logic [4:0] v;
		for (int i = 0; i < 32; i++) begin
			v = 5'(i);
			send(GRP_CONTROL, ctl(0, v[2], v[1:0], v[0], v[4:3], v[1], v[4], v[3:2], v[3]), r);
			check("test mode", test_mode, 0);
			check("polarity", pump_rev, v[2]);
			check("polarity bit", cw.pump_polarity, v[2]);
			check("control word", cw, {1'b0, v[2], v[1:0], v[0], v[4:3], v[1], v[4], v[3:2], v[3]});
			check("ch1 current", ua1, ua(v[1:0]));
			check("ch2 current", ua2, ua(v[4:3]));
			check("powers", {pow1, pow2, powr}, {!v[0], !v[1], !(v[0] & v[1] & v[4])});
			check("filter pin", link.filter_switch_level, !v[3]);
			check("lock pin", link.lock_flag_level, (v[3:2] == 2'h1) ? v[1] : (v[3:2] == 2'h2) ?
				v[0] : (v[3:2] == 2'h3) ? (v[0] & v[1]) : 1'b0);
		end
	endtask
	task automatic t_test();
		logic r;
		logic [3:0] v;
		int e;
		for (int i = 0; i < 16; i++) begin
			v = 4'(i);
			send(GRP_CONTROL, ctl(1, 0, 2'h0, v[0], 2'h0, v[1], 0, v[3:2], 0), r);
			check("test mode", test_mode, 1);
			e = (v[1:0] == 2'h2) ? int'(v[3:2]) : (v[1:0] == 2'h1 && v[3:2] != 2'h0) ?
				int'(v[3:2]) + 3 : -1;
			taps = (e < 0) ? 7'h7f : (7'h01 << e);
			repeat (3) @(negedge clock_i);
			check("tap high", link.lock_flag_level, e >= 0);
			taps = (e < 0) ? 7'h00 : ~taps;
			repeat (3) @(negedge clock_i);
			check("tap low", link.lock_flag_level, 0);
		end
		taps = 7'h00;
	endtask
	task automatic t_lock();
		logic r;
		send(GRP_CONTROL, ctl(0, 0, 2'h0, 0, 2'h0, 0, 0, 2'h3, 0), r);
		pulse(3, 2'h3);
		check("three aligned", chan_locked, 2'h0);
		check("pin unlocked", link.lock_flag_level, 0);
		pulse(1, 2'h3);
		check("four aligned", chan_locked, 2'h3);
		check("pin locked", link.lock_flag_level, 1);
		pulse(1, 2'h1);
		check("ch2 missed", chan_locked, 2'h1);
		check("pin after miss", link.lock_flag_level, 0);
	endtask
	// ====================
	// clock, timeout, sequence
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		supply_ok = 1'b1;
		cmd_valid = 1'b0;
		cmd_group = GRP_CONTROL;
		cmd_payload = 17'h00000;
		ref_pulse = 1'b0;
		chan_pulse = 2'h0;
		taps = 7'h00;
		repeat (12) @(negedge clock_i);
		rst_i = 1'b0;
		check("pin after reset", link.lock_flag_level, 0);
		t_order();
		t_normal();
		t_test();
		t_lock();
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> pll_serial_control_map.svh
// Purpose: offsets, field positions and timing counts of the serial control latches
// Assumes: shift register is 19 bits, filled from the top, least significant bit first
// Notes: positions are bit indices into the shift register after a complete word
`ifndef PLL_SERIAL_CONTROL_MAP_SVH
`define PLL_SERIAL_CONTROL_MAP_SVH

// ==========================================
// shift register layout
`define SR_W 19
`define GC_HI_BIT 18
`define GC_LO_BIT 17
`define SHORT_WORD_BITS 14
`define LONG_WORD_BITS 19

// ==========================================
// control word bits after a 14-bit word
`define CTL_DIAG 5
`define CTL_POL 6
`define CTL_CUR1_A 7
`define CTL_CUR1_B 8
`define CTL_SLEEP1 9
`define CTL_CUR2_A 10
`define CTL_CUR2_B 11
`define CTL_SLEEP2 12
`define CTL_SLEEPR 13
`define CTL_SEL_A 14
`define CTL_SEL_B 15
`define CTL_FILT 16

// ==========================================
// divider latch fields
`define REF_LSB 5
`define REF_W 12
`define SWAL_LSB 0
`define SWAL_W 5
`define MAIN_LSB 5
`define MAIN_W 12

// ==========================================
// charge pump currents in microamps
`define PUMP_UA_00 11'd1600
`define PUMP_UA_01 11'd200
`define PUMP_UA_10 11'd400
`define PUMP_UA_11 11'd800

// ==========================================
// lock detector and link timing
`define LOCK_WIN_PERIODS 2
`define LOCK_STREAK 3'd4
`define CLK_PERIOD_NS 40
`define LINK_PERIOD_NS 320
`define HALF_TICKS ((`LINK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define HALF_LOAD 4'((`HALF_TICKS) - 1)
`define LATCH_LOAD 4'((2 * `HALF_TICKS) - 1)

`endif

// >>> pll_serial_control_pkg.sv
// Purpose: shared types of the serial control link
// Assumes: nothing beyond the map header
// Notes: group codes follow the order high bit then low bit
package pll_serial_control_pkg;
	typedef enum logic [1:0] {
		GRP_CONTROL = 2'h0,
		GRP_CHAN_ONE = 2'h1,
		GRP_CHAN_TWO = 2'h2,
		GRP_REFERENCE = 2'h3
	} group_t;

	typedef struct packed {
		logic diag_mode;
		logic pump_polarity;
		logic [1:0] chan_one_current;
		logic chan_one_sleep;
		logic [1:0] chan_two_current;
		logic chan_two_sleep;
		logic ref_divider_sleep;
		logic lock_out_sel_a;
		logic lock_out_sel_b;
		logic filter_time_constant_sel;
	} control_word_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SET = 3'h1,
		H_RISE = 3'h2,
		H_LATCH = 3'h3,
		H_GAP = 3'h4
	} host_state_t;
endpackage

// >>> pll_serial_link_if.sv
// Purpose: three-wire serial link plus the two open-drain pins
// Assumes: open-drain pins pulled up outside the parts
// Notes: a pin reads low while its enable is high
`timescale 1ns/10ps
`default_nettype none
interface pll_serial_link_if;
	logic sck;
	logic sdata;
	logic sen;
	logic lock_flag_oe;
	logic filter_switch_oe;
	wire logic lock_flag_level;
	wire logic filter_switch_level;

	assign lock_flag_level = ~lock_flag_oe;
	assign filter_switch_level = ~filter_switch_oe;

	modport host_end (
		output sck,
		output sdata,
		output sen,
		input lock_flag_level,
		input filter_switch_level
	);
	modport device_end (
		input sck,
		input sdata,
		input sen,
		output lock_flag_oe,
		output filter_switch_oe
	);
endinterface
`default_nettype wire
